// ===== include/slsf_pkg.sv
// Purpose: Shared constants and types for the serial line status flags.
// Assumes: 32-bit AXI4-Lite register bus, one clock domain.
// Notes: Register offsets are word indices; the byte address is four times that.

// ****************************************************************
// Package
// ****************************************************************
package slsf_pkg;
   // Error flag count and interrupt source count (status bits 4:0).
   localparam int N_ERR = 4;
   localparam int N_INT = 5;
   // Word indices of the registers.
   localparam logic [15:0] SLS_IDX = 16'hFFA5;
   localparam logic [15:0] INT_ST_IDX = 16'hFFB0;
   localparam logic [15:0] INT_MSK_IDX = 16'hFFB1;
   // Byte addresses, four times the index, padded to the bus width on purpose.
   localparam logic [31:0] SLS_ADDR = {14'h0, SLS_IDX, 2'b00};
   localparam logic [31:0] INT_ST_ADDR = {14'h0, INT_ST_IDX, 2'b00};
   localparam logic [31:0] INT_MSK_ADDR = {14'h0, INT_MSK_IDX, 2'b00};
   // Bit positions of the line status byte.
   localparam int OVERRUN_BIT = 0;
   localparam int PAR_BIT = 1;
   localparam int FRM_BIT = 2;
   localparam int BREAK_BIT = 3;
   localparam int RX_FULL_BIT = 4;
   localparam int TX_EMPTY_BIT = 5;
   localparam int TX_IDLE_BIT = 6;
   // Reset values.
   localparam logic TX_EMPTY_RESET = 1'b1;
   localparam logic TX_IDLE_RESET = 1'b1;
   localparam logic [4:0] INT_MSK_RESET = 5'h00;
   // Bus responses.
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Register selected by an address.
   typedef enum logic [1:0] {SEL_NONE, SEL_SLS, SEL_IST, SEL_IMSK} slsf_sel_t;
endpackage : slsf_pkg

// ===== include/slsf_flags_if.sv
// Purpose: Carries receive events and sticky flags between top and core.
// Assumes: Single clock; all signals are levels or one-cycle pulses.
// Notes: The core drives the flags; the top drives the events.
`timescale 1ns/1ps

// ****************************************************************
// Flag interface
// ****************************************************************
interface slsf_flags_if;
   // Parity, framing, break set pulses, bits 2:0 for flags 1..3.
   logic [2:0] err_set;
   // A completed byte enters the holding register.
   logic rx_done;
   // The holding register is read by DMA or the controller.
   logic rx_read;
   // Write-one-to-clear strobes for the four error flags.
   logic [3:0] err_clr;
   // Sticky error flags and the holding-full flag.
   logic [3:0] err_q;
   logic rx_full_q;
   modport core (input err_set, input rx_done, input rx_read, input err_clr,
                 output err_q, output rx_full_q);
   modport top (output err_set, output rx_done, output rx_read, output err_clr,
                input err_q, input rx_full_q);
endinterface : slsf_flags_if

// ===== rtl/slsf_flag_core.sv
// Purpose: Sticky receive error flags and the holding-full flag.
// Assumes: Events are one-cycle pulses synchronous to aclk.
// Notes: A set in the same cycle as a clear wins.
`timescale 1ns/1ps

// ****************************************************************
// Flag core
// ****************************************************************
module slsf_flag_core (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Flag bundle.
   slsf_flags_if.core fl
);
   // Overrun: a new byte lands on an unread one.
   logic overrun_set;
   // Set vector in status byte order.
   logic [3:0] set_v;

   assign overrun_set = fl.rx_done & fl.rx_full_q & ~fl.rx_read;
   assign set_v = {fl.err_set, overrun_set};

   // Holding-full follows arrivals and reads; an arrival wins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fl.rx_full_q <= 1'b0;
      end else if (fl.rx_done) begin
         fl.rx_full_q <= 1'b1;
      end else if (fl.rx_read) begin
         fl.rx_full_q <= 1'b0;
      end
   end

   // Each error flag is sticky and cleared only by a written one.
   for (genvar i = 0; i < slsf_pkg::N_ERR; i++) begin : g_err
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            fl.err_q[i] <= 1'b0;
         end else begin
            fl.err_q[i] <= set_v[i] | (fl.err_q[i] & ~fl.err_clr[i]);
         end
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // A collision of a new byte with an unread one.
   sequence s_collide;
      fl.rx_done && fl.rx_full_q && !fl.rx_read;
   endsequence

   a_overrun_set:
      assert property (s_collide |=> fl.err_q[slsf_pkg::OVERRUN_BIT])
      else $error("overrun flag not set on collision");
   a_err_sticky:
      assert property (1'b1 |=> (($past(fl.err_q) & ~$past(fl.err_clr)) & ~fl.err_q) == 4'h0)
      else $error("error flag dropped without a clear");
   a_par_clear:
      assert property (fl.err_clr[1] && !fl.err_set[0] |=> !fl.err_q[1])
      else $error("parity flag not cleared by written one");
   a_full_track:
      assert property (fl.rx_done || fl.rx_read |=> fl.rx_full_q == $past(fl.rx_done))
      else $error("holding-full flag wrong after arrival or read");
endmodule : slsf_flag_core

// ===== rtl/slsf_top.sv
// Purpose: Line status flags of a serial port with an AXI4-Lite slave.
// Assumes: One clock aclk, synchronous active-low reset aresetn.
// Notes: Error flags halt DMA and feed a maskable interrupt.
`timescale 1ns/1ps

// ****************************************************************
// Top
// ****************************************************************
module slsf_top (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address.
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data.
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address.
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data.
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Receiver events.
   input wire logic rx_byte_done,
   input wire logic rx_parity_bad,
   input wire logic rx_frame_bad,
   input wire logic rx_break_seen,
   input wire logic rx_holding_read,
   // Transmitter state.
   input wire logic tx_holding_empty_in,
   input wire logic tx_shift_empty,
   // To the DMA controller and the interrupt controller.
   output logic dma_halt,
   output logic irq
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   // Flag bundle shared with the core.
   slsf_flags_if fl ();
   // Transmitter flags, registered for a clean read.
   logic tx_holding_empty_q;
   logic transmitter_idle_q;
   // Captured write address and data with their held markers.
   logic [31:0] aw_addr_q;
   logic aw_have_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic w_have_q;
   // Write is performed in the cycle both halves are held.
   logic wr_go;
   slsf_pkg::slsf_sel_t wr_sel;
   // Interrupt status and mask, same layout as status bits 4:0.
   logic [4:0] int_st_q;
   logic [4:0] int_st_d;
   logic [4:0] int_msk_q;
   // Clear strobes from a write, gated by byte lane zero.
   logic [4:0] wr_ones;
   // Registered outputs.
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic dma_halt_q;
   logic irq_q;

   // Map a byte address to the register it names.
   function automatic slsf_pkg::slsf_sel_t sel_of(input logic [31:0] a);
      slsf_pkg::slsf_sel_t s;
      s = slsf_pkg::SEL_NONE;
      if (a == slsf_pkg::SLS_ADDR) begin
         s = slsf_pkg::SEL_SLS;
      end else if (a == slsf_pkg::INT_ST_ADDR) begin
         s = slsf_pkg::SEL_IST;
      end else if (a == slsf_pkg::INT_MSK_ADDR) begin
         s = slsf_pkg::SEL_IMSK;
      end
      return s;
   endfunction : sel_of

   // ****************************************************************
   // Flag core
   // ****************************************************************
   // Parity, framing and break only count with a completed byte.
   assign fl.err_set = {rx_break_seen, rx_frame_bad, rx_parity_bad} & {3{rx_byte_done}};
   assign fl.rx_done = rx_byte_done;
   assign fl.rx_read = rx_holding_read;

   // Write decode and lane-zero ones used by both clear paths.
   assign wr_go = aw_have_q & w_have_q & ~bvalid_q;
   assign wr_sel = sel_of(aw_addr_q);
   assign wr_ones = w_data_q[4:0] & {5{w_strb_q[0] & wr_go}};
   // Writing zero leaves a flag alone; only ones reach the clears.
   assign fl.err_clr = (wr_sel == slsf_pkg::SEL_SLS) ? wr_ones[3:0] : 4'h0;

   slsf_flag_core u_core (
      .aclk(aclk),
      .aresetn(aresetn),
      .fl(fl)
   );

   // ****************************************************************
   // Transmitter flags
   // ****************************************************************
   // Both read as one out of reset and are never written by software.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_holding_empty_q <= slsf_pkg::TX_EMPTY_RESET;
         transmitter_idle_q <= slsf_pkg::TX_IDLE_RESET;
      end else begin
         tx_holding_empty_q <= tx_holding_empty_in;
         // Idle needs the shifter empty as well, not only the holding.
         transmitter_idle_q <= tx_holding_empty_in & tx_shift_empty;
      end
   end

   // ****************************************************************
   // Halt and interrupt
   // ****************************************************************
   // DMA stops while any error flag stands; one cycle after it rises.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_halt_q <= 1'b0;
      end else begin
         dma_halt_q <= |fl.err_q;
      end
   end

   // Status bits are set by the flag levels, so set beats a clear.
   always_comb begin
      int_st_d = int_st_q;
      if (wr_sel == slsf_pkg::SEL_IST) begin
         int_st_d = int_st_d & ~wr_ones;
      end
      int_st_d = int_st_d | {fl.rx_full_q, fl.err_q};
   end

   // Sticky status register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_st_q <= 5'h00;
      end else begin
         int_st_q <= int_st_d;
      end
   end

   // Mask register, written with lane zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_msk_q <= slsf_pkg::INT_MSK_RESET;
      end else if (wr_go && w_strb_q[0] && wr_sel == slsf_pkg::SEL_IMSK) begin
         int_msk_q <= w_data_q[4:0];
      end
   end

   // One level output while any unmasked status bit is set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(int_st_q & int_msk_q);
      end
   end

   // ****************************************************************
   // AXI4-Lite write
   // ****************************************************************
   // Address and data are taken in either order and held.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         aw_addr_q <= 32'h0000_0000;
         awready_q <= 1'b1;
      end else if (s_axi_awvalid && awready_q) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
         awready_q <= 1'b0;
      end else if (wr_go) begin
         aw_have_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
         // Ready again only after the response is gone.
         awready_q <= 1'b1;
      end
   end

   // Data channel mirrors the address channel.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         wready_q <= 1'b1;
      end else if (s_axi_wvalid && wready_q) begin
         w_have_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
         wready_q <= 1'b0;
      end else if (wr_go) begin
         w_have_q <= 1'b0;
      end else if (bvalid_q && s_axi_bready) begin
         wready_q <= 1'b1;
      end
   end

   // Response: unmapped addresses answer with a slave error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= slsf_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= (wr_sel == slsf_pkg::SEL_NONE) ? slsf_pkg::RESP_SLVERR
                                                    : slsf_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ****************************************************************
   // AXI4-Lite read
   // ****************************************************************
   // Reads have no side effects; the data is captured at the handshake.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= slsf_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= slsf_pkg::RESP_OKAY;
         case (sel_of(s_axi_araddr))
            slsf_pkg::SEL_SLS: begin
               // Bit seven is reserved and reads zero.
               rdata_q <= {24'h00_0000, 1'b0, transmitter_idle_q, tx_holding_empty_q,
                           fl.rx_full_q, fl.err_q};
            end
            slsf_pkg::SEL_IST: begin
               rdata_q <= {27'h000_0000, int_st_q};
            end
            slsf_pkg::SEL_IMSK: begin
               rdata_q <= {27'h000_0000, int_msk_q};
            end
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= slsf_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign dma_halt = dma_halt_q;
   assign irq = irq_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // A byte arrives with the given error.
   sequence s_bad(logic e);
      rx_byte_done && e;
   endsequence

   // Flag stands, then halt follows one cycle later.
   sequence s_set_halt(logic f);
      f ##1 dma_halt;
   endsequence

   // Halt checks count from the flag, since the halt register lags it.
   a_dma_halt_any:
      assert property (|fl.err_q |=> dma_halt)
      else $error("DMA not halted with an error flag set");
   a_overrun_halt:
      assert property (rx_byte_done && fl.rx_full_q && !rx_holding_read
                       |=> s_set_halt(fl.err_q[slsf_pkg::OVERRUN_BIT]))
      else $error("overrun did not halt DMA");
   a_parity_halt:
      assert property (s_bad(rx_parity_bad) |=> s_set_halt(fl.err_q[slsf_pkg::PAR_BIT]))
      else $error("parity error did not set flag and halt");
   a_framing_halt:
      assert property (s_bad(rx_frame_bad) |=> s_set_halt(fl.err_q[slsf_pkg::FRM_BIT]))
      else $error("framing error did not set flag and halt");
   a_break_halt:
      assert property (s_bad(rx_break_seen) |=> s_set_halt(fl.err_q[slsf_pkg::BREAK_BIT]))
      else $error("break did not set flag and halt");
   // The mask must still stand when the status bit has caught up.
   a_rx_irq:
      assert property (fl.rx_full_q && int_msk_q[4] ##1 int_msk_q[4] |=> irq)
      else $error("receive interrupt missing");
   // With every source masked the line must stay low.
   a_irq_masked:
      assert property (int_msk_q == 5'h00 |=> !irq)
      else $error("interrupt raised with all sources masked");
   a_tx_flags:
      assert property (!tx_holding_empty_in |=> !tx_holding_empty_q && !transmitter_idle_q)
      else $error("transmit flags wrong while holding full");
   a_idle_shift:
      assert property (!tx_shift_empty |=> !transmitter_idle_q)
      else $error("idle shown with shifter busy");
   a_bit7_zero:
      assert property (rvalid_q |-> !rdata_q[7])
      else $error("reserved bit read as one");
endmodule : slsf_top

// ===== bench/slsf_dma_model.sv
// Purpose: DMA controller that empties the receive holding register.
// Assumes: One clock; one read strobe per byte seen arriving.
// Notes: Latency is set by the bench, so reads can be prompt or slow.
`timescale 1ns/1ps

// ****************************************************************
// DMA partner model
// ****************************************************************
module slsf_dma_model (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bench controls.
   input wire logic dma_en,
   input wire logic [3:0] lat,
   // Watched signals.
   input wire logic rx_byte_done,
   input wire logic dma_halt,
   // Holding register read strobe.
   output logic rd_pulse
);
   // A byte is waiting for this model to fetch it.
   logic pend_q;
   // Cycles still to wait before the fetch.
   logic [3:0] wait_q;

   // Fetch each byte once; a halted channel holds its fetch back.
   always @(posedge aclk) begin
      if (!aresetn) begin
         pend_q <= 1'b0;
         wait_q <= 4'h0;
         rd_pulse <= 1'b0;
      end else begin
         rd_pulse <= 1'b0;
         if (rx_byte_done) begin
            pend_q <= 1'b1;
            wait_q <= lat;
         end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
         end else if (pend_q && dma_en && !dma_halt) begin
            rd_pulse <= 1'b1;
            pend_q <= 1'b0;
         end
      end
   end
endmodule : slsf_dma_model

// ===== bench/test_serial_line_status_flags.sv
// Purpose: Self-checking bench for the serial line status flags.
// Assumes: AXI4-Lite master tasks; DMA model on the holding register.
// Notes: Random events come from an LFSR seeded with 32'hb5a6.
`timescale 1ns/1ps

module test_serial_line_status_flags;
   // Clock, reset and bus signals.
   logic aclk = 0, aresetn = 0;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   // Receiver, transmitter and output signals.
   logic done, par, frm, line_break, tb_read, dma_rd, te, ts, dma_halt, irq;
   logic dma_en;
   logic [3:0] lat;
   // Bench bookkeeping.
   int num_errors = 0, compares = 0, cyc = 0, i, k;
   logic [31:0] s, d;
   logic [1:0] r;
   logic [3:0] e;
   logic f;

   always #5 aclk = ~aclk;

   slsf_top DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_byte_done(done),
      .rx_parity_bad(par), .rx_frame_bad(frm), .rx_break_seen(line_break),
      .rx_holding_read(tb_read | dma_rd), .tx_holding_empty_in(te),
      .tx_shift_empty(ts), .dma_halt(dma_halt), .irq(irq));

   slsf_dma_model dma (.aclk(aclk), .aresetn(aresetn), .dma_en(dma_en), .lat(lat),
      .rx_byte_done(done), .dma_halt(dma_halt), .rd_pulse(dma_rd));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Next value of the stimulus LFSR.
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   // Expected status byte from the modelled flags and transmit levels.
   function automatic logic [31:0] exp_sls(input logic [3:0] ef, input logic hf,
                                           input logic t0, input logic t1);
      exp_sls = {25'h0, t0 & t1, t0, hf, ef};
   endfunction : exp_sls

   task automatic final_report();
      $display("checks %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One write; the master waits for the response, however long.
   task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'h1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            check({30'h0, bresp}, {30'h0, er});
            bready <= 1'b0;
            break;
         end
      end
   endtask : wr

   // One read; data and response are taken at the rvalid edge.
   task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            v = rdata;
            rs = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask : rd

   // Read a mapped register and compare its word.
   task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] v;
      logic [1:0] rs;
      rd(a, v, rs);
      check(v, exp);
      check({30'h0, rs}, {30'h0, slsf_pkg::RESP_OKAY});
   endtask : rchk

   // One-cycle receiver event: bits are read, break, framing, parity, arrival.
   task automatic ev(input logic [4:0] v);
      @(posedge aclk);
      {tb_read, line_break, frm, par, done} <= v;
      @(posedge aclk);
      {tb_read, line_break, frm, par, done} <= 5'h00;
   endtask : ev

   // Hang guard: the full run needs well under a thousand cycles.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         final_report();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, done, par, frm, line_break, tb_read} = 10'h000;
      {awaddr, wdata, araddr, wstrb} = 100'h0;
      {te, ts, dma_en, lat} = 7'h60;
      s = 32'hb5a6;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      check({31'h0, dma_halt | irq}, 32'h0);
      rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h0, 1'b0, 1'b1, 1'b1));
      rchk(slsf_pkg::INT_MSK_ADDR, 32'h0000_0000);
      rd(32'h0000_0100, d, r);
      check(d, 32'h0000_0000);
      check({30'h0, r}, {30'h0, slsf_pkg::RESP_SLVERR});
      wr(32'h0000_0100, 32'hFFFF_FFFF, slsf_pkg::RESP_SLVERR);
      $display("test reset and unmapped done");
      // Each line error: halt, hold through a written zero, clear on a one.
      for (i = 1; i < 4; i++) begin
         ev(5'h01 | (5'h01 << i));
         @(posedge aclk);
         #1 check({31'h0, dma_halt}, 32'h1);
         rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h1 << i, 1'b1, 1'b1, 1'b1));
         wr(slsf_pkg::SLS_ADDR, 32'h0, slsf_pkg::RESP_OKAY);
         rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h1 << i, 1'b1, 1'b1, 1'b1));
         wr(slsf_pkg::SLS_ADDR, 32'h1 << i, slsf_pkg::RESP_OKAY);
         rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h0, 1'b1, 1'b1, 1'b1));
         check({31'h0, dma_halt}, 32'h0);
         ev(5'h10);
         rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h0, 1'b0, 1'b1, 1'b1));
      end
      $display("test error flags done");
      // Each interrupt source alone under its own mask bit.
      for (i = 0; i < 5; i++) begin
         wr(slsf_pkg::INT_ST_ADDR, 32'h1F, slsf_pkg::RESP_OKAY);
         wr(slsf_pkg::INT_MSK_ADDR, 32'h1 << i, slsf_pkg::RESP_OKAY);
         if (i == 0) ev(5'h01);
         ev((i == 0 || i == 4) ? 5'h01 : (5'h01 | (5'h01 << i)));
         repeat (2) @(posedge aclk);
         #1 check({31'h0, irq}, 32'h1);
         rchk(slsf_pkg::SLS_ADDR, exp_sls((i == 4) ? 4'h0 : 4'h1 << i, 1'b1, 1'b1, 1'b1));
         rchk(slsf_pkg::INT_ST_ADDR, 32'h10 | ((i == 4) ? 32'h0 : 32'h1 << i));
         wr(slsf_pkg::SLS_ADDR, 32'h0F, slsf_pkg::RESP_OKAY);
         ev(5'h10);
         wr(slsf_pkg::INT_ST_ADDR, 32'h1F, slsf_pkg::RESP_OKAY);
         repeat (3) @(posedge aclk);
         #1 check({31'h0, irq}, 32'h0);
      end
      // A masked source leaves the line low.
      wr(slsf_pkg::INT_MSK_ADDR, 32'h0, slsf_pkg::RESP_OKAY);
      ev(5'h03);
      repeat (3) @(posedge aclk);
      #1 check({31'h0, irq}, 32'h0);
      // Arrival and read together on a full register is no overrun.
      ev(5'h11);
      rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h2, 1'b1, 1'b1, 1'b1));
      wr(slsf_pkg::SLS_ADDR, 32'h0F, slsf_pkg::RESP_OKAY);
      ev(5'h10);
      $display("test interrupts done");
      // DMA drains a clean byte but is held off by a parity error.
      dma_en <= 1'b1;
      lat <= 4'h1;
      ev(5'h01);
      repeat (8) @(posedge aclk);
      rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h0, 1'b0, 1'b1, 1'b1));
      lat <= 4'h4;
      ev(5'h03);
      repeat (12) @(posedge aclk);
      rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h2, 1'b1, 1'b1, 1'b1));
      wr(slsf_pkg::SLS_ADDR, 32'h02, slsf_pkg::RESP_OKAY);
      repeat (8) @(posedge aclk);
      rchk(slsf_pkg::SLS_ADDR, exp_sls(4'h0, 1'b0, 1'b1, 1'b1));
      dma_en <= 1'b0;
      $display("test dma halt done");
      // Random event bursts against the bench model of the flags.
      e = 4'h0;
      f = 1'b0;
      for (k = 0; k < 12; k++) begin
         for (i = 0; i < 25; i++) begin
            @(posedge aclk);
            s = lfsr(s);
            {tb_read, line_break, frm, par, done} <= s[4:0];
            te <= s[8];
            ts <= s[9];
            if (s[0]) begin
               if (f && !s[4]) e[0] = 1'b1;
               e[3:1] = e[3:1] | s[3:1];
               f = 1'b1;
            end else if (s[4]) begin
               f = 1'b0;
            end
         end
         @(posedge aclk);
         {tb_read, line_break, frm, par, done} <= 5'h00;
         rchk(slsf_pkg::SLS_ADDR, exp_sls(e, f, s[8], s[9]));
         check({31'h0, dma_halt}, {31'h0, |e});
         wr(slsf_pkg::SLS_ADDR, 32'hFF, slsf_pkg::RESP_OKAY);
         e = 4'h0;
         rchk(slsf_pkg::SLS_ADDR, exp_sls(e, f, s[8], s[9]));
      end
      $display("test random done");
      final_report();
   end
endmodule : test_serial_line_status_flags
